// >>> rtl/mcmfw_defs.svh
// Register offsets, field positions, reset values and frame lengths
// Assumes byte offsets on the word-wide CSR command path
`ifndef MCMFW_DEFS_SVH
`define MCMFW_DEFS_SVH
// Register offsets
`define MCMFW_A_HASH_HI   8'h0C
`define MCMFW_A_HASH_LO   8'h10
`define MCMFW_A_MGMT_REQ  8'h14
`define MCMFW_A_MGMT_VAL  8'h18
`define MCMFW_A_FLOW      8'h1C
`define MCMFW_A_TAG1      8'h20
`define MCMFW_A_TAG2      8'h24
`define MCMFW_A_WFILT     8'h28
`define MCMFW_A_WAKE      8'h2C
// Management request fields
`define MCMFW_B_MGMT_BUSY 0
`define MCMFW_B_MGMT_DIR  1
`define MCMFW_F_PHY_HI    15
`define MCMFW_F_PHY_LO    11
`define MCMFW_F_REG_HI    10
`define MCMFW_F_REG_LO    6
// Flow control fields
`define MCMFW_F_PAUSE_HI  31
`define MCMFW_F_PAUSE_LO  16
`define MCMFW_B_PASS_PAUSE 2
`define MCMFW_B_FLOW_ON   1
`define MCMFW_B_FC_BUSY   0
// Wake control and status fields
`define MCMFW_B_GLOBAL_UNI 9
`define MCMFW_B_WFLAG     6
`define MCMFW_B_RFLAG     5
`define MCMFW_B_WFE       2
`define MCMFW_B_RWE       1
// Reset values and frame lengths
`define MCMFW_TAG_RESET   16'hFFFF
`define MCMFW_LEN_PLAIN   11'h5EE
`define MCMFW_LEN_TAG1    11'h5F2
`define MCMFW_LEN_TAG2    11'h602
// Management frame layout, in bit slots
`define MCMFW_PREAMBLE    32'hFFFFFFFF
`define MCMFW_START       2'h1
`define MCMFW_OP_READ     2'h2
`define MCMFW_OP_WRITE    2'h1
`define MCMFW_TA_WRITE    2'h2
`define MCMFW_TA_SLOT     7'h2E
`define MCMFW_SAMPLE_1ST  7'h31
`define MCMFW_IDLE_SLOT   7'h40
`endif

// >>> rtl/mcmfw_pkg.sv
// Types shared by the CSR slice and the management engine
// Assumes mcmfw_defs.svh carries all numeric constants
package mcmfw_pkg;
  // Engine states, one-hot
  typedef enum logic [1:0] {
    MCMFW_IDLE = 2'h1,
    MCMFW_RUN  = 2'h2
  } mcmfw_state_t;
endpackage

// >>> rtl/mcmfw_link_if.sv
// Carrier between the CSR side and the management-link engine
// Assumes toggles cross domains; all fields stand while a toggle is unanswered
`timescale 1ns/100ps
interface mcmfw_link_if;
  logic        reqToggle;  // Flips once per new transaction
  logic [4:0]  phySelect;  // Addressed PHY
  logic [4:0]  regSelect;  // Register inside it
  logic        isWrite;    // 1 = write
  logic [15:0] wrValue;    // Value to send
  logic        doneToggle; // Flips once per finished transaction
  logic [15:0] rdValue;    // Value received
  modport csr    (output reqToggle, phySelect, regSelect, isWrite, wrValue,
                  input doneToggle, rdValue);
  modport engine (input reqToggle, phySelect, regSelect, isWrite, wrValue,
                  output doneToggle, rdValue);
endinterface // mcmfw_link_if

// >>> rtl/mcmfw_mdio_engine.sv
// Serial management engine on the link clock
// Assumes link fields stay stable from request toggle until done toggle
`timescale 1ns/100ps
`include "mcmfw_defs.svh"
module mcmfw_mdio_engine
  import mcmfw_pkg::*;
(
  input  wire logic     linkClk,
  input  wire logic     resetn,
  mcmfw_link_if.engine  link,
  input  wire logic     mdioIn,
  output logic          mdc,
  output logic          mdioOut,
  output logic          mdioOe_n
);
  typedef struct packed {
    mcmfw_state_t state;   // Engine state
    logic         reqS1;   // Request sync, first stage
    logic         reqS2;   // Request sync, second stage
    logic         reqSeen; // Last request served
    logic         mdiS1;   // Pin sync, first stage
    logic         mdiS2;   // Pin sync, second stage
    logic [63:0]  shift;   // Outgoing frame, MSB first
    logic [6:0]   slot;    // Bit slot in frame
    logic         phase;   // 0 = clock low half, 1 = high half
    logic         isRead;  // Current frame is a read
    logic [15:0]  rd;      // Received value
    logic         doneTgl; // Completion toggle
    logic         mdc;     // Management clock out
    logic         mdo;     // Data out
    logic         oe_n;    // Data enable, low = driving
  } mcmfw_eng_t;
  mcmfw_eng_t r, next_r;

  ////////////////////////////////////////////////////////////////////////
  // Frame sequencer: two link cycles per bit, clock rises mid-bit
  always_comb begin
    next_r       = r;
    next_r.reqS1 = link.reqToggle;
    next_r.reqS2 = r.reqS1;
    next_r.mdiS1 = mdioIn;
    next_r.mdiS2 = r.mdiS1;
    unique case (r.state)
      MCMFW_IDLE: begin
        next_r.mdc  = 1'b0;
        next_r.oe_n = 1'b1;
        // New request seen after its toggle settled
        if (r.reqS2 != r.reqSeen) begin
          next_r.reqSeen = r.reqS2;
          next_r.shift   = {`MCMFW_PREAMBLE, `MCMFW_START,
                            link.isWrite ? `MCMFW_OP_WRITE : `MCMFW_OP_READ,
                            link.phySelect, link.regSelect, `MCMFW_TA_WRITE,
                            link.wrValue};
          next_r.slot    = 7'h00;
          next_r.phase   = 1'b0;
          next_r.isRead  = ~link.isWrite;
          next_r.state   = MCMFW_RUN;
        end
      end
      MCMFW_RUN: begin
        if (!r.phase) begin
          // Data changes while the clock is low, valid at the rise
          next_r.mdc   = 1'b0;
          next_r.mdo   = r.shift[63];
          // Released from the read turnaround onward and for the idle slot
          next_r.oe_n  = (r.isRead && r.slot >= `MCMFW_TA_SLOT)
                         || r.slot == `MCMFW_IDLE_SLOT;
          next_r.phase = 1'b1;
        end else begin
          next_r.mdc   = 1'b1;
          next_r.phase = 1'b0;
          next_r.shift = {r.shift[62:0], 1'b0};
          next_r.slot  = r.slot + 7'h01;
          // Synced sample lags the pin by one bit slot
          if (r.isRead && r.slot >= `MCMFW_SAMPLE_1ST)
            next_r.rd = {r.rd[14:0], r.mdiS2};
          if (r.slot == `MCMFW_IDLE_SLOT) begin
            next_r.doneTgl = ~r.doneTgl;
            next_r.state   = MCMFW_IDLE;
          end
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge linkClk or negedge resetn) begin
    if (!resetn) begin
      r       <= '0;
      r.state <= MCMFW_IDLE;
      r.oe_n  <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign link.doneToggle = r.doneTgl;
  assign link.rdValue    = r.rd;
  assign mdc             = r.mdc;
  assign mdioOut         = r.mdo;
  assign mdioOe_n        = r.oe_n;

  // A frame ends after its idle slot, never sooner or later
  AST_FRAME_BITS: assert property (
    @(posedge linkClk) disable iff (!resetn)
    r.state == MCMFW_RUN && r.slot == `MCMFW_IDLE_SLOT && r.phase
    |=> r.state == MCMFW_IDLE && r.doneTgl != $past(r.doneTgl))
    else $error("frame did not end at idle slot");
endmodule // mcmfw_mdio_engine

// >>> rtl/mcmfw_top.sv
// CSR slice of the MAC: hash table, PHY management, pause flow control,
// tag comparators and wake detection
// Assumes a word-wide CSR command path on clk and a free link clock
//
// How it works
// - 64-bit hash in two registers, reset zero
// - PHY address field at bits 15..11
// - PHY register field at bits 10..6
// - Bit 1: 0 read, 1 write
// - Busy bit 0 reads 1 during transactions
// - 16-bit management value, read or write
// - Request register write starts a transaction
// - Preamble, start, opcode, addresses, turnaround, data, idle
// - Device drives clock; data valid rising
// - Pause time field feeds generated frames
// - Pass-pause bit controls packet-filter marking
// - Flow enable gates pause and back-pressure; here flowCtrlOn is only an output and pause requests ignore it
// - Writing busy sends one pause frame, in full duplex only
// - First tag match extends length to 1522
// - Second tag match extends to 1538
// - Eight sequential accesses cover four filters
// - Global unicast bit waives address filter
// - Wake-frame flag bit 6, write-one clear
// - Remote-wake flag bit 5, write-one clear
// - Wake flags reset only by power-on
// - Wake-frame enable sleeps and arms wake
// - Remote-wake enable sleeps and arms wake
`timescale 1ns/100ps
`include "mcmfw_defs.svh"
module mcmfw_top
  import mcmfw_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        porResetn,
  input  wire logic        linkClk,
  input  wire logic [7:0]  csrAddr,
  input  wire logic [31:0] csrWrData,
  input  wire logic        csrWrite,
  input  wire logic        csrRead,
  output logic      [31:0] csrRdData,
  output logic             mdc,
  input  wire logic        mdioIn,
  output logic             mdioOut,
  output logic             mdioOe_n,
  input  wire logic        fullDuplex,
  input  wire logic        pauseSent,
  output logic             pauseRequest,
  output logic      [15:0] pauseTime,
  output logic             flowCtrlOn,
  output logic             passPauseFrames,
  output logic      [63:0] hashBits,
  input  wire logic        rxTagValid,
  input  wire logic [15:0] rxTagBytes,
  output logic      [10:0] maxFrameLen,
  input  wire logic        addrFilterPass,
  input  wire logic        wakeFrameHit,
  input  wire logic        remoteWakeHit,
  output logic             sleepMode,
  output logic             wakeEvent
);
  typedef struct packed {
    logic [31:0]      hashLo;      // Hash bits 31..0
    logic [31:0]      hashHi;      // Hash bits 63..32
    logic [4:0]       phySel;      // phy_select
    logic [4:0]       phyRegSel;   // phy_reg_select
    logic             isWrite;     // Direction
    logic             mgmtBusy;    // Transaction in flight
    logic [15:0]      phyValue;    // phy_value
    logic [15:0]      pauseTime;   // Pause quanta
    logic             passPause;   // pass_pause_frames
    logic             flowOn;      // flow_ctrl_on
    logic             pauseBusy;   // Pause frame pending
    logic [15:0]      tag1;        // first_tag_id
    logic [15:0]      tag2;        // second_tag_id
    logic [2:0]       wfIdx;       // Filter word pointer
    logic [7:0][31:0] wfMem;       // Wake filter words
    logic             globalUni;   // global_unicast_wake
    logic             wfEn;        // wake_frame_enable
    logic             rwEn;        // remote_wake_enable
    logic             sleep;       // Sleep mode
    logic             wakeEv;      // Wake event pulse
    logic             reqTgl;      // Request toggle to link
    logic             ackS1;       // Done sync, first stage
    logic             ackS2;       // Done sync, second stage
    logic             ackSeen;     // Last done handled
    logic [31:0]      rdData;      // Read answer
    logic [10:0]      maxLen;      // Allowed frame length
  } mcmfw_regs_t;
  mcmfw_regs_t r, next_r;

  // Flags live outside the struct: they answer only to power-on
  logic wakeFrameFlag;   // wake_frame_flag
  logic remoteWakeFlag;  // remote_wake_flag

  mcmfw_link_if link ();

  // Decode used by several processes
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Event terms shared by flags and pulses
  logic wakeQualified;  // Address test satisfied or waived
  logic wakeFrameSet;   // Wake frame accepted
  logic remoteSet;      // Remote-wake packet accepted
  logic wakeWrite;      // Write to wake control/status
  logic tag1Match;      // First tag comparator
  logic tag2Match;      // Second tag comparator
  logic pauseStart;     // Software asks for a pause frame
  logic linkDone;       // Engine finished a frame

  always_comb begin
    wakeQualified = r.globalUni | addrFilterPass;
    wakeFrameSet  = r.wfEn & wakeFrameHit & wakeQualified;
    remoteSet     = r.rwEn & remoteWakeHit & wakeQualified;
    wakeWrite     = csrWrite & hit(csrAddr, `MCMFW_A_WAKE);
    // Zero tag never matches
    tag1Match     = (r.tag1 != 16'h0000) && (rxTagBytes == r.tag1);
    tag2Match     = (r.tag2 != 16'h0000) && (rxTagBytes == r.tag2);
    // Ignored outside full duplex
    pauseStart    = csrWrite & hit(csrAddr, `MCMFW_A_FLOW)
                    & csrWrData[`MCMFW_B_FC_BUSY] & fullDuplex;
    linkDone      = r.ackS2 != r.ackSeen;
  end

  ////////////////////////////////////////////////////////////////////////
  // Next-state of the register file
  always_comb begin
    next_r        = r;
    next_r.wakeEv = wakeFrameSet | remoteSet;
    next_r.sleep  = r.wfEn | r.rwEn;
    // Completion crosses back as a toggle
    next_r.ackS1  = link.doneToggle;
    next_r.ackS2  = r.ackS1;

    // Link finished: value first, busy dropped on the same edge
    if (linkDone) begin
      next_r.ackSeen = r.ackS2;
      if (!r.isWrite)
        next_r.phyValue = link.rdValue;
      next_r.mgmtBusy = 1'b0;
    end

    // Pause frame handed over; a fresh request wins
    if (pauseSent)
      next_r.pauseBusy = 1'b0;
    if (pauseStart)
      next_r.pauseBusy = 1'b1;

    // Tag check sets the length limit for the frame
    if (rxTagValid) begin
      if (tag2Match)
        next_r.maxLen = `MCMFW_LEN_TAG2;
      else if (tag1Match)
        next_r.maxLen = `MCMFW_LEN_TAG1;
      else
        next_r.maxLen = `MCMFW_LEN_PLAIN;
    end

    // Software writes
    if (csrWrite) begin
      unique case (1'b1)
        hit(csrAddr, `MCMFW_A_HASH_HI): next_r.hashHi = csrWrData;
        hit(csrAddr, `MCMFW_A_HASH_LO): next_r.hashLo = csrWrData;
        hit(csrAddr, `MCMFW_A_MGMT_REQ): begin
          // Busy rises at once and the engine is kicked
          next_r.phySel    = csrWrData[`MCMFW_F_PHY_HI:`MCMFW_F_PHY_LO];
          next_r.phyRegSel = csrWrData[`MCMFW_F_REG_HI:`MCMFW_F_REG_LO];
          next_r.isWrite   = csrWrData[`MCMFW_B_MGMT_DIR];
          next_r.mgmtBusy  = 1'b1;
          next_r.reqTgl    = ~r.reqTgl;
        end
        hit(csrAddr, `MCMFW_A_MGMT_VAL): next_r.phyValue = csrWrData[15:0];
        hit(csrAddr, `MCMFW_A_FLOW): begin
          next_r.pauseTime = csrWrData[`MCMFW_F_PAUSE_HI:`MCMFW_F_PAUSE_LO];
          next_r.passPause = csrWrData[`MCMFW_B_PASS_PAUSE];
          next_r.flowOn    = csrWrData[`MCMFW_B_FLOW_ON];
        end
        hit(csrAddr, `MCMFW_A_TAG1): next_r.tag1 = csrWrData[15:0];
        hit(csrAddr, `MCMFW_A_TAG2): next_r.tag2 = csrWrData[15:0];
        hit(csrAddr, `MCMFW_A_WFILT): begin
          next_r.wfMem[r.wfIdx] = csrWrData;
          next_r.wfIdx          = r.wfIdx + 3'h1;
        end
        hit(csrAddr, `MCMFW_A_WAKE): begin
          next_r.globalUni = csrWrData[`MCMFW_B_GLOBAL_UNI];
          next_r.wfEn      = csrWrData[`MCMFW_B_WFE];
          next_r.rwEn      = csrWrData[`MCMFW_B_RWE];
        end
        default: ;
      endcase
    end

    // Reads answer one cycle later; filter reads also step the pointer
    if (csrRead) begin
      unique case (1'b1)
        hit(csrAddr, `MCMFW_A_HASH_HI): next_r.rdData = r.hashHi;
        hit(csrAddr, `MCMFW_A_HASH_LO): next_r.rdData = r.hashLo;
        hit(csrAddr, `MCMFW_A_MGMT_REQ):
          next_r.rdData = {16'h0000, r.phySel, r.phyRegSel, 4'h0,
                           r.isWrite, r.mgmtBusy};
        hit(csrAddr, `MCMFW_A_MGMT_VAL): next_r.rdData = {16'h0000, r.phyValue};
        hit(csrAddr, `MCMFW_A_FLOW):
          next_r.rdData = {r.pauseTime, 13'h0000, r.passPause, r.flowOn,
                           r.pauseBusy};
        hit(csrAddr, `MCMFW_A_TAG1): next_r.rdData = {16'h0000, r.tag1};
        hit(csrAddr, `MCMFW_A_TAG2): next_r.rdData = {16'h0000, r.tag2};
        hit(csrAddr, `MCMFW_A_WFILT): begin
          next_r.rdData = r.wfMem[r.wfIdx];
          next_r.wfIdx  = r.wfIdx + 3'h1;
        end
        hit(csrAddr, `MCMFW_A_WAKE):
          next_r.rdData = {22'h000000, r.globalUni, 2'h0, wakeFrameFlag,
                           remoteWakeFlag, 2'h0, r.wfEn, r.rwEn, 1'b0};
        default: next_r.rdData = 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register file, reset by resetn only; tags load FFFF, maxLen loads the plain length, the rest clears
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r        <= '0;
      r.tag1   <= `MCMFW_TAG_RESET;
      r.tag2   <= `MCMFW_TAG_RESET;
      r.maxLen <= `MCMFW_LEN_PLAIN;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Wake flags: power-on reset only; a new event beats a clear
  always_ff @(posedge clk or negedge porResetn) begin
    if (!porResetn) begin
      wakeFrameFlag  <= 1'b0;
      remoteWakeFlag <= 1'b0;
    end else begin
      wakeFrameFlag  <= wakeFrameSet |
                        (wakeFrameFlag & ~(wakeWrite & csrWrData[`MCMFW_B_WFLAG]));
      remoteWakeFlag <= remoteSet |
                        (remoteWakeFlag & ~(wakeWrite & csrWrData[`MCMFW_B_RFLAG]));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Link side; fields are stable while busy since software waits
  assign link.reqToggle = r.reqTgl;
  assign link.phySelect = r.phySel;
  assign link.regSelect = r.phyRegSel;
  assign link.isWrite   = r.isWrite;
  assign link.wrValue   = r.phyValue;

  mcmfw_mdio_engine u_engine (
    .linkClk  (linkClk),
    .resetn   (resetn),
    .link     (link),
    .mdioIn   (mdioIn),
    .mdc      (mdc),
    .mdioOut  (mdioOut),
    .mdioOe_n (mdioOe_n)
  );

  // Outputs, all from flops
  assign csrRdData       = r.rdData;
  assign pauseRequest    = r.pauseBusy;
  assign pauseTime       = r.pauseTime;
  assign flowCtrlOn      = r.flowOn;
  assign passPauseFrames = r.passPause;
  assign hashBits        = {r.hashHi, r.hashLo};
  assign maxFrameLen     = r.maxLen;
  assign sleepMode       = r.sleep;
  assign wakeEvent       = r.wakeEv;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_MGMT_BUSY_SET: assert property (
    csrWrite && csrAddr == `MCMFW_A_MGMT_REQ |=> r.mgmtBusy && r.reqTgl != $past(r.reqTgl))
    else $error("request write did not raise busy and kick link");
  AST_MGMT_BUSY_CLR: assert property (
    $fell(r.mgmtBusy) |-> $past(r.ackS2) != $past(r.ackSeen))
    else $error("busy dropped without link completion");
  AST_MGMT_READ_VAL: assert property (
    linkDone && !r.isWrite && !csrWrite |=> r.phyValue == $past(link.rdValue) && !r.mgmtBusy)
    else $error("read value not loaded at completion");
  AST_PAUSE_START: assert property (
    pauseStart |=> pauseRequest)
    else $error("pause request not raised");
  AST_PAUSE_DONE: assert property (
    pauseSent && !pauseStart |=> !pauseRequest)
    else $error("pause busy not cleared after send");
  AST_TAG2_LEN: assert property (
    rxTagValid && tag2Match |=> maxFrameLen == `MCMFW_LEN_TAG2)
    else $error("second tag length wrong");
  AST_TAG1_LEN: assert property (
    rxTagValid && tag1Match && !tag2Match |=> maxFrameLen == `MCMFW_LEN_TAG1)
    else $error("first tag length wrong");
  AST_WAKE_FLAG: assert property (
    r.wfEn && wakeFrameHit && (r.globalUni || addrFilterPass) |=> wakeFrameFlag && wakeEvent)
    else $error("wake frame flag not set");
  AST_WAKE_GATED: assert property (
    !r.globalUni && !addrFilterPass && !remoteSet |=> !wakeEvent)
    else $error("wake event without address pass");

  ////////////////////////////////////////////////////////////////////////
  // Checks on further paths; the bench drives some once, others for many cycles
  // Remote-wake packet marks its own flag and pulses the event
  AST_REMOTE_FLAG: assert property (
    remoteSet |=> remoteWakeFlag && wakeEvent)
    else $error("remote wake flag not set");
  // Clear works only when no fresh event races it: set wins
  AST_WAKE_CLEAR: assert property (
    wakeWrite && csrWrData[`MCMFW_B_WFLAG] && !wakeFrameSet |=> !wakeFrameFlag)
    else $error("wake frame flag not cleared");
  // Either enable puts the MAC to sleep on the next edge
  AST_SLEEP: assert property (
    r.wfEn || r.rwEn |=> sleepMode)
    else $error("sleep mode not entered");
  // No tag hit falls back to the plain limit
  AST_PLAIN_LEN: assert property (
    rxTagValid && !tag1Match && !tag2Match |=> maxFrameLen == `MCMFW_LEN_PLAIN)
    else $error("untagged length wrong");
  // Upper hash word lands in the upper half of the table
  AST_HASH_WRITE: assert property (
    csrWrite && csrAddr == `MCMFW_A_HASH_HI |=> hashBits[63:32] == $past(csrWrData))
    else $error("hash high word not stored");
  // Half duplex never raises a pause request
  AST_PAUSE_DUPLEX: assert property (
    !pauseRequest && !fullDuplex |=> !pauseRequest)
    else $error("pause requested outside full duplex");
  // Request fields reach the link as written
  AST_MGMT_FIELDS: assert property (
    csrWrite && csrAddr == `MCMFW_A_MGMT_REQ
    |=> link.phySelect == $past(csrWrData[`MCMFW_F_PHY_HI:`MCMFW_F_PHY_LO])
        && link.regSelect == $past(csrWrData[`MCMFW_F_REG_HI:`MCMFW_F_REG_LO]))
    else $error("request fields not captured");
endmodule // mcmfw_top

// >>> verification/mcmfw_phy_model.sv
// Behavioural PHY on the serial management link
// Assumes the device shifts on mdc low and the pin has a pull-up
`timescale 1ns/100ps
module mcmfw_phy_model (
  input  wire logic mdc,
  input  wire logic mdioOut,
  input  wire logic mdioOe_n,
  output logic      mdioIn
);
  logic [15:0] wrSeen;         // Data bits of the last frame, read or write
  logic [13:0] hdr;            // Start, opcode, phy, reg
  int          ones = 0;       // Preamble run length
  int          slot = -1;      // Bit slot, -1 between frames
  logic        drive = 1'b0;   // Model owns the pin
  logic        bitOut = 1'b1;  // Level the model drives
  // Released pin floats high, so stale data never lingers
  assign mdioIn = !mdioOe_n ? mdioOut : (drive ? bitOut : 1'b1);
  // Decode on the rising edge, where data is valid
  always @(posedge mdc) begin
    if (slot < 0) begin
      if (!mdioOe_n && !mdioIn && ones >= 32) slot = 32;
      ones = mdioIn ? ones + 1 : 0;
    end else slot = slot + 1;
    if (slot >= 32 && slot <= 45) hdr = {hdr[12:0], mdioIn};
    if (slot >= 48 && slot <= 63) wrSeen = {wrSeen[14:0], mdioIn};
    if (slot == 64) slot = -1;
  end
  // Change on the falling edge so each bit stands over the next rise
  always @(negedge mdc) begin
    drive = (hdr[11:10] == 2'b10) && slot >= 46 && slot <= 62;
    bitOut = (slot == 46) ? 1'b0 : 1'(16'hA5C3 >> ((62 - slot) & 15));
  end
endmodule // mcmfw_phy_model

// >>> verification/mac_csr_mgmt_flow_wake_tb.sv
// Self-checking bench for the CSR slice with a PHY model on the link
// Assumes word-wide CSR strobes and a free-running link clock
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module mac_csr_mgmt_flow_wake_tb;
  logic clk = 0, linkClk = 0, resetn = 0, porResetn = 0, csrWrite = 0, csrRead = 0;
  logic fullDuplex = 0, pauseSent = 0, rxTagValid = 0, addrFilterPass = 0;
  logic wakeFrameHit = 0, remoteWakeHit = 0, ev, mdc, mdioIn, mdioOut, mdioOe_n;
  logic pauseRequest, flowCtrlOn, passPauseFrames, sleepMode, wakeEvent;
  logic [7:0] csrAddr = 8'h00;
  logic [31:0] csrWrData = 32'h0, csrRdData, rd;
  logic [15:0] rxTagBytes = 16'h0, pauseTime;
  logic [63:0] hashBits;
  logic [10:0] maxFrameLen;
  int errors = 0, checked = 0;
  // Reset map: hash, request, value, flow, tags, filter, wake, unmapped
  logic [7:0] ra [10] = '{8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h3C};
  logic [31:0] rv [10] = '{0, 0, 0, 0, 0, 32'hFFFF, 32'hFFFF, 0, 0, 0};
  always #2.5 clk = ~clk;
  always #6 linkClk = ~linkClk;
  mcmfw_top i_dut (.*);
  mcmfw_phy_model i_phy (.*);
  task automatic finish_test;
    if (errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk) csrAddr = a;
    csrWrData = d;
    csrWrite = 1'b1;
    @(negedge clk) csrWrite = 1'b0;
  endtask
  // Answer is registered on the read edge, settled by the next fall
  task automatic get(input logic [7:0] a);
    @(negedge clk) csrAddr = a;
    csrRead = 1'b1;
    @(negedge clk) csrRead = 1'b0;
    rd = csrRdData;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string n);
    get(a);
    `CHK(n, e, rd)
  endtask
  // Poll the engine busy bit under a bound
  task automatic waitIdle;
    int i;
    rd = 32'h1;
    for (i = 0; i < 1000 && rd[0] !== 1'b0; i++) get(8'h14);
    if (rd[0] !== 1'b0) begin errors++; finish_test; end
  endtask
  task automatic tag(input logic [15:0] t, input logic [10:0] e);
    @(negedge clk) rxTagValid = 1'b1;
    rxTagBytes = t;
    @(negedge clk) rxTagValid = 1'b0;
    `CHK("maxFrameLen", e, maxFrameLen)
  endtask
  // A pulse may land in either of two cycles; a pulse in either counts as seen
  task automatic wake(input logic f, r, a, e);
    @(negedge clk) wakeFrameHit = f;
    remoteWakeHit = r;
    addrFilterPass = a;
    @(negedge clk) ev = wakeEvent;
    wakeFrameHit = 1'b0;
    remoteWakeHit = 1'b0;
    @(negedge clk) ev = ev | wakeEvent;
    `CHK("wakeEvent", e, ev)
  endtask
  initial begin
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    porResetn = 1'b1;
    for (int i = 0; i < 10; i++) rdc(ra[i], rv[i], "reset");
    wr(8'h0C, 32'h89ABCDEF);
    wr(8'h10, 32'h01234567);
    `CHK("hashBits", 64'h89ABCDEF01234567, hashBits)
    wr(8'h18, 32'h0000BEEF);
    wr(8'h14, 32'h0000AA82);
    rdc(8'h14, 32'h0000AA83, "busy");
    waitIdle;
    `CHK("header", 14'h16AA, i_phy.hdr)
    `CHK("wrData", 16'hBEEF, i_phy.wrSeen)
    wr(8'h14, 32'h000019C0);
    waitIdle;
    `CHK("header", 14'h1867, i_phy.hdr)
    rdc(8'h18, 32'h0000A5C3, "rdValue");
    wr(8'h1C, 32'h0BCD0007);
    `CHK("pauseRequest", 1'b0, pauseRequest)
    `CHK("pauseTime", 16'h0BCD, pauseTime)
    `CHK("flowBits", 2'h3, {flowCtrlOn, passPauseFrames})
    fullDuplex = 1'b1;
    wr(8'h1C, 32'h0BCD0007);
    rdc(8'h1C, 32'h0BCD0007, "flowBusy");
    @(negedge clk) pauseSent = 1'b1;
    @(negedge clk) pauseSent = 1'b0;
    rdc(8'h1C, 32'h0BCD0006, "flowDone");
    wr(8'h20, 32'h00008100);
    wr(8'h24, 32'h00009100);
    tag(16'h8100, 11'h5F2);
    tag(16'h9100, 11'h602);
    tag(16'h1234, 11'h5EE);
    wr(8'h20, 32'h0);
    tag(16'h0000, 11'h5EE);
    for (int i = 0; i < 8; i++) wr(8'h28, 32'h11111111 * i);
    for (int i = 0; i < 8; i++) rdc(8'h28, 32'h11111111 * i, "filter");
    wr(8'h2C, 32'h00000004);
    wake(1'b1, 1'b0, 1'b0, 1'b0);
    `CHK("sleepMode", 1'b1, sleepMode)
    wake(1'b1, 1'b0, 1'b1, 1'b1);
    wake(1'b0, 1'b1, 1'b1, 1'b0);
    wr(8'h2C, 32'h00000202);
    wake(1'b0, 1'b1, 1'b0, 1'b1);
    @(negedge clk) resetn = 1'b0;
    @(negedge clk) resetn = 1'b1;
    `CHK("hashReset", 64'h0, hashBits)
    rdc(8'h2C, 32'h00000060, "flags");
    wr(8'h2C, 32'h00000040);
    rdc(8'h2C, 32'h00000020, "clear");
    @(negedge clk) porResetn = 1'b0;
    @(negedge clk) porResetn = 1'b1;
    rdc(8'h2C, 32'h0, "powerOn");
    finish_test;
  end
endmodule // mac_csr_mgmt_flow_wake_tb
